// file: qld_pkg.sv
// Package: register map, field positions and reset values of the quick link drop registers
package qld_pkg;

  // ==========================================================================
  // Register word indices (byte address = 4 * index)
  // ==========================================================================
  localparam logic [7:0] IDX_DROP_CTRL  = 8'h2D;
  localparam logic [7:0] IDX_DROP_THR   = 8'h2E;
  localparam logic [7:0] IDX_CFG_FOUR   = 8'h31;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h41;
  localparam logic [7:0] IDX_PHY_STATUS = 8'h42;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int FORCE_DROP_BIT   = 15;
  localparam int DROP_EN_BIT      = 14;
  localparam int CAUSE_LSB        = 8;
  localparam int NUM_CRIT         = 5;
  localparam int TEST_SEL_BIT     = 7;
  localparam int MIRROR_BIT       = 0;
  localparam int REQ_FLAG_BIT     = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [2:0]  THR_RESET       = 3'h1;
  localparam logic [2:0]  THR_STRAP_RESET = 3'h2;
  localparam logic [2:0]  THR_HI_RESET    = 3'h2;
  localparam logic [2:0]  THR_MID_RESET   = 3'h2;
  localparam logic [15:0] CONFIG_FOUR_RO_VALUE   = 16'h1010;

  // Interrupt event bits
  localparam int IRQ_DROP_BIT   = 0;
  localparam int IRQ_ENERGY_BIT = 1;
  localparam int NUM_IRQ        = 2;

endpackage : qld_pkg

// file: qld_top.sv
// Quick link drop configuration and status register bank on classic Wishbone
//
// How it works
// - Force drop makes partner drop on no signal
// - Enabled drop acts in gigabit operation only
// - Cause bits latch high on each drop
// - Cause latched only for enabled criteria
// - Cause bits 12..8 map five criteria
// - Five independent source enables in bits 4..0
// - Energy lost when accumulator below threshold
// - Strap enable makes threshold default 0x2
// - Receive control strap enters internal test
// - Register flag zero marks strap test request
// - Writing zero cancels strapped test mode
// - Mirror enable strap default, writable
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps

module qld_top #(
  parameter int ACC_W = 8                  // Energy accumulator width
) (
  input  wire logic             clk_i,           // 25 MHz clock
  input  wire logic             rst_i,           // Synchronous reset, high
  // Wishbone classic slave
  input  wire logic             cyc_i,           // Bus cycle
  input  wire logic             stb_i,           // Strobe
  input  wire logic             we_i,            // Write enable
  input  wire logic [9:0]       adr_i,           // Byte address
  input  wire logic [3:0]       sel_i,           // Byte selects
  input  wire logic [31:0]      dat_i,           // Write data
  output logic      [31:0]      dat_o,           // Read data
  output logic                  ack_o,           // Acknowledge
  output logic                  err_o,           // Unmapped address
  // Straps, sampled after reset release
  input  wire logic             strap_drop_en_i, // Strap sets threshold default 0x2
  input  wire logic             strap_test_i,    // Receive control strap in mode1/2
  input  wire logic             strap_mirror_i,  // Mirror strap
  // Link side status
  input  wire logic             gig_mode_i,      // Link runs 1000BASE-T
  input  wire logic             link_up_i,       // Link established
  input  wire logic             no_signal_i,     // No signal received
  input  wire logic [3:0]       crit_i,          // Sync, rx err, mlt3, snr
  input  wire logic [ACC_W-1:0] energy_acc_i,    // Energy detector accumulator
  // Controls out
  output logic                  drop_link_o,     // Drop link now
  output logic                  force_partner_o, // Force partner to drop
  output logic                  test_mode_o,     // Internal test mode
  output logic                  mirror_o,        // Port mirroring
  output logic                  irq_o            // Level interrupt
);

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  logic                  force_drop_r;
  logic                  drop_en_r;
  logic [4:0]            src_sel_r;
  logic [4:0]            cause_r;
  logic [4:0]            cause_nxt;
  logic [2:0]            thr_r;
  logic [2:0]            thr_hi_r;
  logic [2:0]            thr_mid_r;
  logic                  test_sel_r;
  logic                  req_flag_r;
  logic                  cfg8_r;
  logic                  mirror_r;
  logic                  strap_pend_r;
  logic [1:0]            irq_sts_r;
  logic [1:0]            irq_mask_r;
  logic                  ack_r;
  logic                  energy_lost;
  logic [4:0]            crit_all;
  logic [4:0]            fire;
  logic                  drop_now;
  logic                  drop_prev_r;
  logic                  energy_prev_r;
  logic                  acc;
  logic                  wr;
  logic                  rd;
  logic [7:0]            idx;
  logic                  mapped;

  // Byte lane merge for a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : lane_merge

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  assign idx    = adr_i[9:2];
  // Err blocks a retake as ack does, so each answer is a single pulse
  assign acc    = cyc_i && stb_i && !ack_r && !err_o;
  assign wr     = acc && we_i;
  assign rd     = acc && !we_i;
  assign mapped = (idx == qld_pkg::IDX_DROP_CTRL) || (idx == qld_pkg::IDX_DROP_THR) ||
                  (idx == qld_pkg::IDX_CFG_FOUR) || (idx == qld_pkg::IDX_IRQ_STATUS) ||
                  (idx == qld_pkg::IDX_IRQ_MASK) || (idx == qld_pkg::IDX_PHY_STATUS);

  // One wait-free answer: ack or err in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_r <= acc && mapped;
      err_o <= acc && !mapped;
    end
  end
  assign ack_o = ack_r;

  // ==========================================================================
  // Drop detection
  // ==========================================================================
  // Threshold widened to accumulator width before compare
  assign energy_lost = energy_acc_i < ACC_W'(thr_r);
  assign crit_all    = {crit_i, energy_lost};
  // Only enabled criteria count, only in gigabit with the feature on
  assign fire        = crit_all & src_sel_r & {5{drop_en_r && gig_mode_i}};
  assign drop_now    = |fire;

  // Drop and force outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_link_o     <= 1'b0;
      force_partner_o <= 1'b0;
    end else begin
      drop_link_o     <= drop_now;
      force_partner_o <= force_drop_r && no_signal_i;
    end
  end

  // ==========================================================================
  // Latched cause bits, clear on read
  // ==========================================================================
  // A criterion still active on the read cycle survives, so nothing is lost
  always_comb begin
    cause_nxt = cause_r;
    if (rd && idx == qld_pkg::IDX_DROP_CTRL) begin
      cause_nxt = fire;
    end
    cause_nxt = cause_nxt | fire;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= 5'h00;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ==========================================================================
  // Control register writes and strap capture
  // ==========================================================================
  // Straps are caught on the first clock after reset release, not under reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_drop_r <= 1'b0;
      drop_en_r    <= 1'b0;
      src_sel_r    <= 5'h00;
      thr_r        <= qld_pkg::THR_RESET;
      thr_hi_r     <= qld_pkg::THR_HI_RESET;
      thr_mid_r    <= qld_pkg::THR_MID_RESET;
      test_sel_r   <= 1'b0;
      req_flag_r   <= 1'b1;
      cfg8_r       <= 1'b0;
      mirror_r     <= 1'b0;
      strap_pend_r <= 1'b1;
    end else if (strap_pend_r) begin
      strap_pend_r <= 1'b0;
      if (strap_drop_en_i) begin
        thr_r <= qld_pkg::THR_STRAP_RESET;
      end
      test_sel_r <= strap_test_i;
      req_flag_r <= !strap_test_i;
      mirror_r   <= strap_mirror_i;
    end else if (wr) begin
      unique case (idx)
        qld_pkg::IDX_DROP_CTRL: begin
          if (sel_i[1]) begin
            force_drop_r <= dat_i[qld_pkg::FORCE_DROP_BIT];
            drop_en_r    <= dat_i[qld_pkg::DROP_EN_BIT];
          end
          if (sel_i[0]) begin
            src_sel_r <= dat_i[4:0];
          end
        end
        qld_pkg::IDX_DROP_THR: begin
          if (sel_i[1]) begin
            thr_hi_r <= dat_i[10:8];
          end
          if (sel_i[0]) begin
            thr_mid_r <= dat_i[6:4];
            thr_r     <= dat_i[2:0];
          end
        end
        qld_pkg::IDX_CFG_FOUR: begin
          if (sel_i[1]) begin
            cfg8_r <= dat_i[qld_pkg::REQ_FLAG_BIT];
          end
          if (sel_i[0]) begin
            test_sel_r <= dat_i[qld_pkg::TEST_SEL_BIT];
            mirror_r   <= dat_i[qld_pkg::MIRROR_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign test_mode_o = test_sel_r;
  assign mirror_o    = mirror_r;

  // ==========================================================================
  // Interrupts: sticky status, write one to clear, set wins
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_prev_r   <= 1'b0;
      energy_prev_r <= 1'b0;
      irq_sts_r     <= 2'h0;
      irq_mask_r    <= 2'h0;
    end else begin
      drop_prev_r   <= drop_now;
      energy_prev_r <= energy_lost;
      if (wr && idx == qld_pkg::IDX_IRQ_MASK && sel_i[0]) begin
        irq_mask_r <= dat_i[1:0];
      end
      irq_sts_r <= (irq_sts_r &
                    ~((wr && idx == qld_pkg::IDX_IRQ_STATUS && sel_i[0]) ? dat_i[1:0] : 2'h0))
                   | {energy_lost && !energy_prev_r, drop_now && !drop_prev_r};
    end
  end
  assign irq_o = |(irq_sts_r & irq_mask_r);

  // ==========================================================================
  // Read data, registered
  // ==========================================================================
  // Unused bits and reserved fields read zero unless a fixed value applies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      unique case (idx)
        qld_pkg::IDX_DROP_CTRL:  dat_o <= {16'h0000, force_drop_r, drop_en_r, 1'b0, cause_r,
                                           3'h0, src_sel_r};
        qld_pkg::IDX_DROP_THR:   dat_o <= {21'h000000, thr_hi_r, 1'b0, thr_mid_r, 1'b0, thr_r};
        qld_pkg::IDX_CFG_FOUR:   dat_o <= {16'h0000, qld_pkg::CONFIG_FOUR_RO_VALUE[15:9],
                                           req_flag_r && cfg8_r == cfg8_r, test_sel_r,
                                           qld_pkg::CONFIG_FOUR_RO_VALUE[6:1], mirror_r};
        qld_pkg::IDX_IRQ_STATUS: dat_o <= {30'h00000000, irq_sts_r};
        qld_pkg::IDX_IRQ_MASK:   dat_o <= {30'h00000000, irq_mask_r};
        qld_pkg::IDX_PHY_STATUS: dat_o <= {29'h00000000, link_up_i, gig_mode_i, energy_lost};
        default:                 dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_force_partner: assert property (@(posedge clk_i) disable iff (rst_i)
    (force_drop_r && no_signal_i) |=> force_partner_o)
    else $error("force partner drop missing");

  a_drop_gig_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (!gig_mode_i || !drop_en_r) |=> !drop_link_o)
    else $error("drop outside gigabit or disabled");

  a_cause_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    fire[0] |=> cause_r[0])
    else $error("cause bit not latched");

  a_cause_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(cause_r[4]) |-> $past(src_sel_r[4])))
    else $error("cause latched for disabled criterion");

  a_energy_thr: assert property (@(posedge clk_i) disable iff (rst_i)
    (drop_en_r && gig_mode_i && src_sel_r[0] && energy_acc_i < ACC_W'(thr_r)) |=> drop_link_o)
    else $error("energy loss not detected");

  a_strap_thr: assert property (@(posedge clk_i) disable iff (rst_i)
    (strap_pend_r && !rst_i && strap_drop_en_i) |=> thr_r == qld_pkg::THR_STRAP_RESET)
    else $error("strap threshold wrong");

  a_test_strap: assert property (@(posedge clk_i) disable iff (rst_i)
    (strap_pend_r && !rst_i) |=> (test_mode_o == $past(strap_test_i)))
    else $error("test mode not taken from strap");

  a_cause_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && idx == qld_pkg::IDX_DROP_CTRL && fire == 5'h00) |=> cause_r == 5'h00)
    else $error("cause not cleared on read");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

  a_err_once: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o |=> !err_o)
    else $error("err held two cycles");

  a_force_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(force_drop_r && no_signal_i) |=> !force_partner_o)
    else $error("force partner drop without cause");

  a_drop_fires: assert property (@(posedge clk_i) disable iff (rst_i)
    (fire != 5'h00) |=> drop_link_o)
    else $error("enabled criterion did not drop link");

  a_cause_all: assert property (@(posedge clk_i) disable iff (rst_i)
    (fire != 5'h00) |=> ((cause_r & $past(fire)) == $past(fire)))
    else $error("cause bit missing for firing criterion");

  a_cause_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(rd && idx == qld_pkg::IDX_DROP_CTRL) |=> ((cause_r & $past(cause_r)) == $past(cause_r)))
    else $error("cause bit lost without read");

  a_cause_source: assert property (@(posedge clk_i) disable iff (rst_i)
    (cause_r & ~$past(cause_r) & ~$past(src_sel_r)) == 5'h00)
    else $error("cause set for disabled source");

  a_src_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == qld_pkg::IDX_DROP_CTRL && sel_i[0] && !strap_pend_r) |=>
      src_sel_r == $past(dat_i[4:0]))
    else $error("source enables not written");

  a_test_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == qld_pkg::IDX_CFG_FOUR && sel_i[0] && !strap_pend_r &&
     !dat_i[qld_pkg::TEST_SEL_BIT]) |=> !test_mode_o)
    else $error("test mode not cancelled by write");

  a_mirror_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == qld_pkg::IDX_CFG_FOUR && sel_i[0] && !strap_pend_r) |=>
      mirror_o == $past(dat_i[qld_pkg::MIRROR_BIT]))
    else $error("mirror enable not written");

  a_irq_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (drop_now && !drop_prev_r) |=> irq_sts_r[qld_pkg::IRQ_DROP_BIT])
    else $error("drop event lost in status");

endmodule : qld_top

// file: qld_link_model.sv
// Link partner model feeding line status and degradation criteria to the drop logic
`timescale 1ns/1ps

// ============================================================================
// Link partner model
// ============================================================================
module qld_link_model #(
  parameter int ACC_W = 8                      // Accumulator width
) (
  input  wire logic             clk_i,         // Clock
  input  wire logic             rst_i,         // Synchronous reset, high
  input  wire logic             drop_i,        // Local side drops the link
  input  wire logic             force_i,       // Local side forces a drop
  input  wire logic             relink_i,      // Bring the link up
  input  wire logic             quiet_i,       // Stop sending any signal
  input  wire logic             gig_c_i,       // Negotiate gigabit
  input  wire logic [3:0]       crit_c_i,      // Criteria to raise
  input  wire logic [ACC_W-1:0] acc_c_i,       // Energy level to present
  output logic                  link_up_o,     // Link established
  output logic                  gig_o,         // Gigabit operation
  output logic                  no_sig_o,      // No signal received
  output logic      [3:0]       crit_o,        // Raised criteria
  output logic      [ACC_W-1:0] acc_o          // Energy accumulator
);
  // A drop outranks bring-up, so a still-firing cause keeps the link down
  always_ff @(posedge clk_i) begin
    if (rst_i || drop_i || force_i) begin
      link_up_o <= 1'b0;
    end else if (relink_i) begin
      link_up_o <= 1'b1;
    end
  end

  // Line conditions follow the commands one clock later, like a real detector
  always_ff @(posedge clk_i) begin
    gig_o    <= gig_c_i && !rst_i;
    no_sig_o <= quiet_i && !rst_i;
    crit_o   <= rst_i ? 4'h0 : crit_c_i;
    acc_o    <= rst_i ? {ACC_W{1'b1}} : acc_c_i;
  end
endmodule : qld_link_model

// file: qld_top_tb.sv
// Self-checking bench for the quick link drop register bank
`timescale 1ns/1ps

// ============================================================================
// Bench top
// ============================================================================
module qld_top_tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, er, relink, quiet, gig_c;
  logic        strap_drop_en_i, strap_test_i, strap_mirror_i, gig_mode_i, link_up_i;
  logic        no_signal_i, drop_link_o, force_partner_o, test_mode_o, mirror_o, irq_o, hit;
  logic [9:0]  adr_i;
  logic [3:0]  sel_i, crit_i, crit_c;
  logic [31:0] dat_i, dat_o;
  logic [7:0]  energy_acc_i, acc_c;
  logic [15:0] rd;
  logic [4:0]  src;
  int          n_errors, comparisons, seed, k, n;

  // Free-running 25 MHz clock
  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  qld_top qld_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .strap_drop_en_i(strap_drop_en_i), .strap_test_i(strap_test_i),
    .strap_mirror_i(strap_mirror_i), .gig_mode_i(gig_mode_i), .link_up_i(link_up_i),
    .no_signal_i(no_signal_i), .crit_i(crit_i), .energy_acc_i(energy_acc_i),
    .drop_link_o(drop_link_o), .force_partner_o(force_partner_o), .test_mode_o(test_mode_o),
    .mirror_o(mirror_o), .irq_o(irq_o));

  qld_link_model qld_link_model_inst (.clk_i(clk_i), .rst_i(rst_i), .drop_i(drop_link_o),
    .force_i(force_partner_o), .relink_i(relink), .quiet_i(quiet), .gig_c_i(gig_c),
    .crit_c_i(crit_c), .acc_c_i(acc_c), .link_up_o(link_up_i), .gig_o(gig_mode_i),
    .no_sig_o(no_signal_i), .crit_o(crit_i), .acc_o(energy_acc_i));

  // ==========================================================================
  // Expectations and reporting
  // ==========================================================================
  function automatic logic [15:0] exp_config_four(input logic tst, input logic req, input logic mir);
    exp_config_four = qld_pkg::CONFIG_FOUR_RO_VALUE;
    exp_config_four[qld_pkg::TEST_SEL_BIT] = tst;
    exp_config_four[qld_pkg::REQ_FLAG_BIT] = !req;
    exp_config_four[qld_pkg::MIRROR_BIT] = mir;
  endfunction : exp_config_four

  // Enable stays set in every control word read back by the drop test
  function automatic logic [15:0] exp_ctrl(input logic [4:0] cause, input logic [4:0] s);
    exp_ctrl = {3'b010, cause, 3'h0, s};
  endfunction : exp_ctrl

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask : tick

  // Classic single cycle; held until ack or err is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1 && err_o !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rd = dat_o[15:0];
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic rc(input logic [7:0] idx, input logic [15:0] exp, input string name);
    wb(1'b0, idx, 16'h0000);
    check(name, {er, rd}, {1'b0, exp});
  endtask : rc

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {rst_i, cyc_i, stb_i, we_i, relink, quiet, strap_drop_en_i, strap_test_i} = '0;
    {strap_mirror_i, adr_i, dat_i, crit_c, n_errors, comparisons} = '0;
    sel_i = 4'h3;
    gig_c = 1'b1;
    acc_c = 8'hFF;
    seed = 42889;
    // Reset values under both strap settings, the second one left in place
    for (int r = 0; r < 2; r++) begin
      strap_drop_en_i <= r[0];
      strap_test_i <= r[0];
      strap_mirror_i <= r[0];
      rst_i <= 1'b1;
      tick(20);
      rst_i <= 1'b0;
      tick(2);
      rc(qld_pkg::IDX_DROP_CTRL, 16'h0000, "ctrl reset");
      rc(qld_pkg::IDX_DROP_THR, r ? 16'h0222 : 16'h0221, "thr reset");
      rc(qld_pkg::IDX_CFG_FOUR, exp_config_four(r[0], r[0], r[0]), "config_four");
      check("test_mode_o", test_mode_o, r[0]);
      check("mirror_o", mirror_o, r[0]);
    end
    $display("Test reset values done");
    // Software overrides the strapped test mode, then toggles mirroring
    wb(1'b1, qld_pkg::IDX_CFG_FOUR, 16'h0000);
    check("test_mode_o", test_mode_o, 1'b0);
    check("mirror_o", mirror_o, 1'b0);
    rc(qld_pkg::IDX_CFG_FOUR, exp_config_four(1'b0, 1'b1, 1'b0), "config_four wr");
    wb(1'b1, qld_pkg::IDX_CFG_FOUR, 16'h0001);
    check("mirror_o", mirror_o, 1'b1);
    // Threshold back to 1, then accumulator at and just below it
    wb(1'b1, qld_pkg::IDX_DROP_THR, 16'h0221);
    rc(qld_pkg::IDX_DROP_THR, 16'h0221, "thr wr");
    sel_i <= 4'h2;
    wb(1'b1, qld_pkg::IDX_DROP_THR, 16'h0000);
    sel_i <= 4'h3;
    rc(qld_pkg::IDX_DROP_THR, 16'h0021, "thr hi lane");
    acc_c <= 8'h01;
    tick(3);
    rc(qld_pkg::IDX_PHY_STATUS, 16'h0002, "acc at thr");
    acc_c <= 8'h00;
    tick(3);
    rc(qld_pkg::IDX_PHY_STATUS, 16'h0003, "acc below thr");
    rc(qld_pkg::IDX_IRQ_STATUS, 16'h0002, "irq energy");
    wb(1'b1, qld_pkg::IDX_IRQ_MASK, 16'h0002);
    check("irq_o energy", irq_o, 1'b1);
    wb(1'b1, qld_pkg::IDX_IRQ_STATUS, 16'h0003);
    check("irq_o energy clr", irq_o, 1'b0);
    acc_c <= 8'hFF;
    wb(1'b0, 8'h2F, 16'h0000);
    check("err_o", er, 1'b1);
    $display("Test config and threshold done");
    // Forced drop only while the line is silent
    wb(1'b1, qld_pkg::IDX_DROP_CTRL, 16'h8000);
    quiet <= 1'b1;
    tick(3);
    check("force_partner_o", force_partner_o, 1'b1);
    quiet <= 1'b0;
    tick(3);
    check("force_partner_o", force_partner_o, 1'b0);
    // Each criterion in turn with random enables; pass 7 runs below gigabit
    wb(1'b1, qld_pkg::IDX_IRQ_MASK, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      k = i % 5;
      src = (i == 0) ? 5'h1F : 5'($random(seed));
      gig_c <= (i != 7);
      wb(1'b1, qld_pkg::IDX_DROP_CTRL, {11'h000, src});
      relink <= 1'b1;
      n = 0;
      do begin
        tick(1);
        n++;
      end while (link_up_i !== 1'b1 && n < 20);
      if (link_up_i !== 1'b1) begin
        n_errors++;
        test_done();
      end
      relink <= 1'b0;
      wb(1'b1, qld_pkg::IDX_DROP_CTRL, exp_ctrl(5'h00, src));
      if (k == 0) acc_c <= 8'h00;
      else crit_c <= 4'h1 << (k - 1);
      tick(3);
      hit = src[k] && (i != 7);
      check("drop_link_o", drop_link_o, hit);
      check("irq_o", irq_o, hit);
      crit_c <= 4'h0;
      acc_c <= 8'hFF;
      tick(2);
      rc(qld_pkg::IDX_DROP_CTRL, exp_ctrl(5'(hit) << k, src), "cause");
      rc(qld_pkg::IDX_DROP_CTRL, exp_ctrl(5'h00, src), "cause clr");
      rc(qld_pkg::IDX_IRQ_STATUS, {14'h0000, k == 0, hit}, "irq sts");
      wb(1'b1, qld_pkg::IDX_IRQ_STATUS, 16'h0003);
      check("irq_o clr", irq_o, 1'b0);
    end
    $display("Test drop criteria done");
    test_done();
  end
endmodule : qld_top_tb
